// ### core/fpir_cfg.svh
// Constants for the frame and packet inquiry register bank.
`ifndef FPIR_CFG_SVH
`define FPIR_CFG_SVH

// Byte offsets from the custom-format base address.
`define FPIR_OFS_CODING_CAPS 12'h014
`define FPIR_OFS_PIXEL_COUNT 12'h034
`define FPIR_OFS_BYTES_UPPER 12'h038
`define FPIR_OFS_BYTES_LOWER 12'h03C
`define FPIR_OFS_PKT_LIMITS 12'h040
`define FPIR_OFS_PKT_SIZE 12'h044

// Coding identifiers and their bytes per pixel.
`define FPIR_ID_MONO8 8'h00
`define FPIR_ID_MONO16 8'h05
`define FPIR_BPP_MONO8 3'h1
`define FPIR_BPP_MONO16 3'h2

// Capability bits are numbered from the top, so coding n sits at bit 31-n.
`define FPIR_CODING_CAPS 32'h8400_0000

// Packet size step, largest packet and reset packet size.
`define FPIR_PKT_UNIT 16'h0004
`define FPIR_PKT_MAX 16'h1000
`define FPIR_PKT_RESET 16'h1000

// Largest number of packets a frame may need.
`define FPIR_PPF_LIMIT 32'h0000_0FFF

// Quadlet alignment mask and pad.
`define FPIR_QUAD_PAD 64'h0000_0000_0000_0003
`define FPIR_QUAD_MASK 64'hFFFF_FFFF_FFFF_FFFC

`endif

// ### core/fpir_pkg.sv
// Types shared by the frame and packet inquiry register bank.
package fpir_pkg;

  // Recompute sequencer states.
  typedef enum logic [1:0] {
    FPIR_PPF_GO,
    FPIR_PPF_WAIT,
    FPIR_REC_GO,
    FPIR_REC_WAIT
  } fpir_seq_e;

  typedef logic [63:0] fpir_bytes_t;

endpackage : fpir_pkg

// ### core/fpir_div.sv
// Iterative divider that returns the quotient rounded up.
`timescale 1ns/1ps
`default_nettype none

module fpir_div #(
  parameter int W = 64
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic START,
  input wire logic [W-1:0] DIVIDEND,
  input wire logic [W-1:0] DIVISOR,
  output logic DONE,
  output logic [W-1:0] QUOTIENT
);

  logic [W-1:0] quo;
  logic [W-1:0] rem;
  logic [W-1:0] dsr;
  logic [$clog2(W+1)-1:0] cnt;
  logic busy;
  logic [W:0] trial;
  logic [W-1:0] next_rem;
  logic take;

  // One restoring step shifts in the next dividend bit and subtracts if it fits.
  assign trial = {rem, quo[W-1]} - {1'b0, dsr};
  assign take = ~trial[W];
  assign next_rem = take ? trial[W-1:0] : {rem[W-2:0], quo[W-1]};

  // Step counter and partial results; a zero divisor yields all ones.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      quo <= '0;
      rem <= '0;
      dsr <= '0;
      cnt <= '0;
      busy <= 1'b0;
      DONE <= 1'b0;
      QUOTIENT <= '0;
    end
    else
    begin
      DONE <= 1'b0;
      if (START)
      begin
        quo <= DIVIDEND;
        rem <= '0;
        dsr <= DIVISOR;
        cnt <= ($clog2(W+1))'(W);
        busy <= 1'b1;
      end
      else if (busy && cnt != '0)
      begin
        rem <= next_rem;
        quo <= {quo[W-2:0], take};
        cnt <= cnt - 1'b1;
      end
      else if (busy)
      begin
        busy <= 1'b0;
        DONE <= 1'b1;
        QUOTIENT <= (dsr == '0) ? '1 : quo + W'(rem != '0);
      end
    end
  end

endmodule : fpir_div

`default_nettype wire

// ### core/fpir_regs.sv
// Frame size and packet parameter inquiry registers of the custom format.
//
// Notes on behaviour
// R1 - Each capability bit reads one for a supported coding identifier and zero otherwise.
// R2 - Offset 0x034 reads the full 32-bit pixel count of a frame from the current width and height.
// R3 - Total frame bytes are 64 bits, upper quadlet at 0x038 and lower quadlet at 0x03C.
// R4 - Total frame bytes track size and coding and count image, padding and appended feature bytes.
// R5 - The top half of 0x040 reads the packet size step, which is 4.
// R6 - The bottom half of 0x040 reads the largest packet size, which is 4096.
// R7 - The top half of 0x044 is the host-written packet size used as payload size.
// R8 - A smaller packet size raises the number of packets per frame to match.
// R9 - The host keeps packets per frame at or below 4095, else frames go wrong.
// R10 - The bottom half of 0x044 is read-only and gives the smallest packet size for top frame rate.
// R11 - The recommended packet size is recomputed after every change of the settings.
// R12 - Bit 0 of every quadlet is its most significant bit.
// R13 - A register sits at the custom-format base plus its byte offset.
// R14 - Reads have no side effects and writes to read-only bits are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "fpir_cfg.svh"

module fpir_regs (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [11:0] REQ_OFFSET,
  input wire logic [31:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic RSP_ERR,
  output logic [31:0] RSP_RDATA,
  input wire logic [15:0] AOI_WIDTH,
  input wire logic [15:0] AOI_HEIGHT,
  input wire logic [7:0] CODING_ID,
  input wire logic [31:0] EXTRA_BYTES,
  input wire logic [15:0] FRAME_PKT_BUDGET,
  output logic [15:0] PKT_SIZE,
  output logic [31:0] PKTS_PER_FRAME,
  output logic PKT_OVER_LIMIT,
  output fpir_pkg::fpir_bytes_t FRAME_BYTES
);
  import fpir_pkg::*;

  fpir_seq_e state;
  fpir_seq_e next_state;
  logic [15:0] rec_size;
  logic [31:0] pixel_count;
  logic [2:0] bytes_per_pixel;
  fpir_bytes_t image_bytes;
  fpir_bytes_t total_bytes;
  logic div_start;
  logic div_done;
  logic [63:0] div_divisor;
  logic [63:0] div_quot;
  logic [63:0] rec_quad;
  logic [15:0] budget;
  logic [15:0] next_rec;
  logic [31:0] read_mux;
  logic hit;
  logic wr_pkt;

  // Maps an offset to whether it is a register of this bank.
  function automatic logic is_mapped(input logic [11:0] ofs);
    is_mapped = (ofs == `FPIR_OFS_CODING_CAPS) || (ofs == `FPIR_OFS_PIXEL_COUNT) ||
                (ofs == `FPIR_OFS_BYTES_UPPER) || (ofs == `FPIR_OFS_BYTES_LOWER) ||
                (ofs == `FPIR_OFS_PKT_LIMITS) || (ofs == `FPIR_OFS_PKT_SIZE);
  endfunction : is_mapped

  // Frame geometry: pixels, bytes per pixel and padded total with feature bytes.
  assign pixel_count = AOI_WIDTH * AOI_HEIGHT; // R2
  assign bytes_per_pixel = (CODING_ID == `FPIR_ID_MONO16) ? `FPIR_BPP_MONO16 : `FPIR_BPP_MONO8;
  assign image_bytes = 64'(pixel_count) * 64'(bytes_per_pixel);
  assign total_bytes = ((image_bytes + `FPIR_QUAD_PAD) & `FPIR_QUAD_MASK) + 64'(EXTRA_BYTES); // R4

  // Shared divider serves packets per frame and the recommended size in turn.
  assign budget = (FRAME_PKT_BUDGET == 16'h0000) ? `FPIR_PKT_MAX : FRAME_PKT_BUDGET;
  assign div_start = (state == FPIR_PPF_GO) || (state == FPIR_REC_GO);
  assign div_divisor = (state == FPIR_PPF_GO) ? 64'(PKT_SIZE) : 64'(budget);

  fpir_div #(
    .W(64)
  ) u_div (
    .MCLK(MCLK),
    .RST(RST),
    .START(div_start),
    .DIVIDEND(total_bytes),
    .DIVISOR(div_divisor),
    .DONE(div_done),
    .QUOTIENT(div_quot)
  );

  // Recommended size rounds up to the packet step and stays within the maximum.
  assign rec_quad = (div_quot + `FPIR_QUAD_PAD) & `FPIR_QUAD_MASK;
  // An empty frame still recommends one packet step, never a zero size.
  assign next_rec = (rec_quad > 64'(`FPIR_PKT_MAX)) ? `FPIR_PKT_MAX :
                    (rec_quad < 64'(`FPIR_PKT_UNIT)) ? `FPIR_PKT_UNIT : rec_quad[15:0]; // R10

  // The sequencer loops forever so every setting change is picked up.
  always_comb
  begin
    next_state = state;
    unique case (state)
      FPIR_PPF_GO: next_state = FPIR_PPF_WAIT;
      FPIR_PPF_WAIT: if (div_done) next_state = FPIR_REC_GO;
      FPIR_REC_GO: next_state = FPIR_REC_WAIT;
      FPIR_REC_WAIT: if (div_done) next_state = FPIR_PPF_GO; // R11
    endcase
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      state <= FPIR_PPF_GO;
    else
      state <= next_state;
  end

  // Latch divider results as they come out.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      PKTS_PER_FRAME <= '0;
      rec_size <= `FPIR_PKT_MAX;
    end
    else if (div_done && state == FPIR_PPF_WAIT)
      PKTS_PER_FRAME <= div_quot[31:0]; // R8
    else if (div_done && state == FPIR_REC_WAIT)
      rec_size <= next_rec; // R11
  end

  // Frame bytes and limit flag follow the live settings.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      FRAME_BYTES <= '0;
      PKT_OVER_LIMIT <= 1'b0;
    end
    else
    begin
      FRAME_BYTES <= total_bytes; // R3
      PKT_OVER_LIMIT <= PKTS_PER_FRAME > `FPIR_PPF_LIMIT; // R9
    end
  end

  // Only the top half of the packet size quadlet takes writes.
  assign hit = is_mapped(REQ_OFFSET); // R13
  assign wr_pkt = REQ_VALID && REQ_WRITE && (REQ_OFFSET == `FPIR_OFS_PKT_SIZE); // R14

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      PKT_SIZE <= `FPIR_PKT_RESET;
    else if (wr_pkt)
      PKT_SIZE <= REQ_WDATA[31:16]; // R7 R12
  end

  // Read selection; fields named from bit 0 sit in the upper half.
  assign read_mux =
    (REQ_OFFSET == `FPIR_OFS_CODING_CAPS) ? `FPIR_CODING_CAPS : // R1
    (REQ_OFFSET == `FPIR_OFS_PIXEL_COUNT) ? pixel_count :
    (REQ_OFFSET == `FPIR_OFS_BYTES_UPPER) ? total_bytes[63:32] : // R3
    (REQ_OFFSET == `FPIR_OFS_BYTES_LOWER) ? total_bytes[31:0] :
    (REQ_OFFSET == `FPIR_OFS_PKT_LIMITS) ? {`FPIR_PKT_UNIT, `FPIR_PKT_MAX} : // R5 R6 R12
    (REQ_OFFSET == `FPIR_OFS_PKT_SIZE) ? {PKT_SIZE, rec_size} : 32'h0000_0000;

  // Every access is answered one cycle later; reads change no state.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      RSP_VALID <= 1'b0;
      RSP_ERR <= 1'b0;
      RSP_RDATA <= '0;
    end
    else
    begin
      RSP_VALID <= REQ_VALID;
      RSP_ERR <= REQ_VALID && !hit;
      RSP_RDATA <= (REQ_VALID && !REQ_WRITE) ? read_mux : 32'h0000_0000; // R14
    end
  end

  // Operands of the running packets-per-frame divide, kept for its check.
  logic [63:0] ppf_total;
  logic [15:0] ppf_size;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ppf_total <= '0;
      ppf_size <= '0;
    end
    else if (state == FPIR_PPF_GO)
    begin
      ppf_total <= total_bytes;
      ppf_size <= PKT_SIZE;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  a_caps_read: assert property (REQ_VALID && !REQ_WRITE && REQ_OFFSET == `FPIR_OFS_CODING_CAPS |=> // R1
    RSP_RDATA[31] && RSP_RDATA[26] && RSP_RDATA[25:0] == 26'h0000000 && RSP_RDATA[30:27] == 4'h0)
    else $error("Coding capability bits read wrong.");
  a_pixel_read: assert property (REQ_VALID && !REQ_WRITE && REQ_OFFSET == `FPIR_OFS_PIXEL_COUNT |=> // R2
    RSP_RDATA == 32'($past(AOI_WIDTH) * $past(AOI_HEIGHT)))
    else $error("Pixel count read does not match width times height.");
  a_bytes_split: assert property (REQ_VALID && !REQ_WRITE && REQ_OFFSET == `FPIR_OFS_BYTES_LOWER |=> // R3
    RSP_RDATA == FRAME_BYTES[31:0])
    else $error("Lower frame byte quadlet wrong.");
  a_total_covers: assert property (total_bytes >= image_bytes + 64'(EXTRA_BYTES) && // R4
    total_bytes < image_bytes + 64'(EXTRA_BYTES) + 64'h4)
    else $error("Frame byte total misses image, pad or feature bytes.");
  a_limits_read: assert property (REQ_VALID && !REQ_WRITE && REQ_OFFSET == `FPIR_OFS_PKT_LIMITS |=> // R5 R6
    RSP_RDATA == 32'h0004_1000)
    else $error("Packet limits read wrong.");
  a_size_write: assert property (wr_pkt |=> PKT_SIZE == $past(REQ_WDATA[31:16]) ##1 // R7
    (REQ_VALID && !REQ_WRITE && REQ_OFFSET == `FPIR_OFS_PKT_SIZE) [*1] |=> RSP_RDATA[31:16] == PKT_SIZE)
    else $error("Packet size write not taken.");
  a_ppf_ceil: assert property (div_done && state == FPIR_PPF_WAIT && ppf_size != 16'h0000 |=> // R8
    65'(PKTS_PER_FRAME) * 65'(ppf_size) >= 65'(ppf_total) &&
    65'(PKTS_PER_FRAME) * 65'(ppf_size) < 65'(ppf_total) + 65'(ppf_size))
    else $error("Packets per frame not the rounded-up quotient.");
  a_rec_aligned: assert property (rec_size[1:0] == 2'b00 && rec_size <= `FPIR_PKT_MAX && rec_size != 16'h0) // R10
    else $error("Recommended packet size out of step or range.");
  a_recompute_loop: assert property (state == FPIR_REC_GO |-> ##[1:140] state == FPIR_PPF_GO) // R11
    else $error("Recommended size not recomputed in time.");
  a_ro_ignored: assert property (REQ_VALID && REQ_WRITE && REQ_OFFSET != `FPIR_OFS_PKT_SIZE |=> $stable(PKT_SIZE)) // R14
    else $error("Write to read-only register changed packet size.");
  a_answer_next: assert property (REQ_VALID |=> RSP_VALID && (RSP_ERR == !$past(hit))) // R13
    else $error("Access not answered next cycle.");

  c_size_write: cover property (wr_pkt ##1 REQ_VALID && !REQ_WRITE && REQ_OFFSET == `FPIR_OFS_PKT_SIZE);
  c_ppf_done: cover property (div_done && state == FPIR_PPF_WAIT);
  c_over_limit: cover property (PKT_OVER_LIMIT);
  c_unmapped: cover property (RSP_ERR);

endmodule : fpir_regs

`default_nettype wire

// ### tb/fpir_host_model.sv
// Host model that issues quadlet accesses to the inquiry registers.
`timescale 1ns/1ps
`default_nettype none

module fpir_host_model (
  input wire logic MCLK,
  output logic REQ_VALID,
  output logic REQ_WRITE,
  output logic [11:0] REQ_OFFSET,
  output logic [31:0] REQ_WDATA,
  input wire logic RSP_VALID,
  input wire logic RSP_ERR,
  input wire logic [31:0] RSP_RDATA
);
  // Quiet bus from time zero.
  initial
  begin
    REQ_VALID = 1'b0;
    REQ_WRITE = 1'b0;
    REQ_OFFSET = 12'h000;
    REQ_WDATA = 32'h0000_0000;
  end

  // One access: a one-cycle request, then a bounded wait for the answer.
  task automatic xfer(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0000_0000;
    er = 1'b0;
    @(negedge MCLK);
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_OFFSET = ofs;
    REQ_WDATA = wd;
    for (n = 0; n < 4 && ok == 1'b0; n++)
    begin
      @(negedge MCLK);
      REQ_VALID = 1'b0;
      if (RSP_VALID === 1'b1)
      begin
        ok = 1'b1;
        rd = RSP_RDATA;
        er = RSP_ERR;
      end
    end
    // Released lines show a changed pattern, never the old request.
    REQ_WRITE = ~wr;
    REQ_OFFSET = ~ofs;
    REQ_WDATA = ~wd;
  endtask : xfer
endmodule : fpir_host_model

`default_nettype wire

// ### tb/fpir_regs_tb_top.sv
// Self-checking testbench of the frame and packet inquiry registers.
`timescale 1ns/1ps
`default_nettype none

module fpir_regs_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rv, rw, rsv, rse, ovr;
  logic [11:0] ro;
  logic [31:0] wd, rsd, extra, ppf;
  logic [15:0] wid = 16'h0010, hgt = 16'h0008, bud = 16'h0004, psz;
  logic [7:0] cid = 8'h05;
  logic [63:0] fb;
  logic [31:0] d;
  logic e;
  int fail_count = 0;
  int cmp_count = 0;

  initial extra = 32'h0000_0006;

  // Clock of 25 ns period.
  always #12.5 mclk = ~mclk;

  fpir_regs DUT (.MCLK(mclk), .RST(rst), .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_OFFSET(ro),
    .REQ_WDATA(wd), .RSP_VALID(rsv), .RSP_ERR(rse), .RSP_RDATA(rsd), .AOI_WIDTH(wid),
    .AOI_HEIGHT(hgt), .CODING_ID(cid), .EXTRA_BYTES(extra), .FRAME_PKT_BUDGET(bud),
    .PKT_SIZE(psz), .PKTS_PER_FRAME(ppf), .PKT_OVER_LIMIT(ovr), .FRAME_BYTES(fb));

  fpir_host_model host (.MCLK(mclk), .REQ_VALID(rv), .REQ_WRITE(rw), .REQ_OFFSET(ro),
    .REQ_WDATA(wd), .RSP_VALID(rsv), .RSP_ERR(rse), .RSP_RDATA(rsd));

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // Compares one result and reports a mismatch at once.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One register access; a missing answer ends the run.
  task automatic acc(input logic w, input logic [11:0] o, input logic [31:0] v);
    logic ok;
    host.xfer(w, o, v, d, e, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      complete_run();
    end
  endtask : acc

  // Lets the derived results follow a change of the settings.
  task automatic settle();
    repeat (300) @(negedge mclk);
  endtask : settle

  // Values seen straight after reset.
  task automatic t_reset();
    acc(1'b0, 12'h044, 32'h0);
    chk(d, 32'h1000_1000);
    chk(psz, 16'h1000);
    acc(1'b0, 12'h040, 32'h0);
    chk(d, 32'h0004_1000);
    acc(1'b0, 12'h014, 32'h0);
    chk(d, 32'h8400_0000);
    $display("test reset done");
  endtask : t_reset

  // Pixel count and frame bytes for 16x8 at two bytes a pixel plus 6, then 3x3 padded.
  task automatic t_frame();
    settle();
    acc(1'b0, 12'h034, 32'h0);
    chk(d, 32'd128);
    acc(1'b0, 12'h038, 32'h0);
    chk(d, 32'h0);
    acc(1'b0, 12'h03C, 32'h0);
    chk(d, 32'd262);
    chk(fb, 64'd262);
    wid = 16'h0003;
    hgt = 16'h0003;
    cid = 8'h00;
    extra = 32'h0;
    settle();
    acc(1'b0, 12'h03C, 32'h0);
    chk(d, 32'd12);
    wid = 16'h0010;
    hgt = 16'h0008;
    cid = 8'h05;
    extra = 32'h0000_0006;
    $display("test frame done");
  endtask : t_frame

  // Packet size writes, packets per frame and the recommended size.
  task automatic t_pkt();
    acc(1'b1, 12'h044, 32'h0040_FFFF);
    chk(psz, 16'h0040);
    settle();
    chk(ppf, 32'd5);
    chk(ovr, 1'b0);
    acc(1'b0, 12'h044, 32'h0);
    chk(d, 32'h0040_0044);
    acc(1'b1, 12'h044, 32'h0020_0000);
    bud = 16'h0002;
    settle();
    chk(ppf, 32'd9);
    acc(1'b0, 12'h044, 32'h0);
    chk(d, 32'h0020_0084);
    $display("test packet done");
  endtask : t_pkt

  // Read-only places keep their values; an unmapped offset is refused.
  task automatic t_ro();
    acc(1'b1, 12'h040, 32'hFFFF_FFFF);
    acc(1'b1, 12'h034, 32'h0);
    acc(1'b0, 12'h040, 32'h0);
    chk(d, 32'h0004_1000);
    acc(1'b0, 12'h034, 32'h0);
    chk(d, 32'd128);
    acc(1'b0, 12'h0F0, 32'h0);
    chk({e, d}, 33'h1_0000_0000);
    $display("test read-only done");
  endtask : t_ro

  // A packet size too small for the frame, as the host must not do.
  task automatic t_limit();
    wid = 16'd200;
    hgt = 16'd100;
    cid = 8'h00;
    extra = 32'h0;
    acc(1'b1, 12'h044, 32'h0004_0000);
    settle();
    chk(ppf, 32'd5000);
    chk(ovr, 1'b1);
    acc(1'b0, 12'h044, 32'h0);
    chk(d, 32'h0004_1000);
    $display("test limit done");
  endtask : t_limit

  // Main sequence.
  initial
  begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_frame();
    t_pkt();
    t_ro();
    t_limit();
    complete_run();
  end
endmodule : fpir_regs_tb_top

`default_nettype wire
